/* logic/srg_pkg.sv */
// Package for the serial rate generator: register map, fields and state
package srg_pkg;
  // ************************************
  // Register offsets
  // ************************************
  localparam logic [2:0] SRG_RATE_CONTROL = 3'h0;
  localparam logic [2:0] SRG_DIV_LOW = 3'h1;
  localparam logic [2:0] SRG_DIV_HIGH = 3'h2;
  localparam logic [2:0] SRG_PORT_CONTROL = 3'h3;
  localparam logic [2:0] SRG_IRQ_STATUS = 3'h4;
  localparam logic [2:0] SRG_IRQ_MASK = 3'h5;
  localparam logic [2:0] SRG_LINE_STATUS = 3'h6;
  // ************************************
  // Field positions and masks
  // ************************************
  localparam int SRG_RC_OVF = 7;
  localparam int SRG_RC_IDLE = 6;
  localparam int SRG_RC_POL = 4;
  localparam int SRG_RC_WIDE = 3;
  localparam int SRG_RC_WAKE = 1;
  localparam int SRG_RC_ARD = 0;
  localparam logic [7:0] SRG_RC_WMASK = 8'h9b;
  localparam int SRG_PC_EN = 0;
  localparam int SRG_PC_SYNC = 1;
  localparam int SRG_PC_HS = 2;
  localparam int SRG_PC_MASTER = 3;
  localparam logic [7:0] SRG_PC_WMASK = 8'h0f;
  localparam int SRG_IRQ_WAKE = 0;
  localparam int SRG_IRQ_DONE = 1;
  localparam int SRG_IRQ_OVF = 2;
  // ************************************
  // Prescaler terminal counts and reset values
  // ************************************
  localparam logic [6:0] SRG_PRE_64 = 7'h3f;
  localparam logic [6:0] SRG_PRE_16 = 7'h0f;
  localparam logic [6:0] SRG_PRE_4 = 7'h03;
  localparam logic [6:0] SRG_PRE_SYNC = 7'h01;
  localparam logic [2:0] SRG_ABD_SUB = 3'h7;
  localparam logic [2:0] SRG_ABD_RISES = 3'h4;
  localparam logic [7:0] SRG_RC_RST = 8'h00;
  localparam logic [7:0] SRG_PC_RST = 8'h00;
  // ************************************
  // Types
  // ************************************
  typedef enum logic [1:0] {
    SRG_ABD_IDLE = 2'b00,
    SRG_ABD_WAIT = 2'b01,
    SRG_ABD_MEAS = 2'b10
  } srg_abd_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } srg_bus_t;
  typedef struct packed {
    logic [7:0] rc;
    logic [15:0] div;
    logic [7:0] pc;
    logic [2:0] ist;
    logic [2:0] imask;
    logic [6:0] pre;
    logic [15:0] cnt;
    logic tick;
    logic sck;
    logic [2:0] rx_hist;
    logic rx_lvl;
    logic rx_prev;
    logic ext_prev;
    srg_abd_t abd;
    logic [2:0] abd_sub;
    logic [2:0] rises;
    logic [15:0] meas;
    logic wake_arm;
    logic [7:0] rdata;
  } srg_state_t;
  localparam srg_state_t SRG_STATE_RST = '{
    rc: SRG_RC_RST, pc: SRG_PC_RST, rx_hist: 3'h7, rx_lvl: 1'b1,
    rx_prev: 1'b1, abd: SRG_ABD_IDLE, default: '0};
endpackage

/* logic/srg_rate_gen.sv */
// Serial port rate generator with auto rate detect, wake-up and rx vote
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - Counter is 8-bit after reset; wide select makes it 16-bit, high byte ignored else.
// - One divisor counter serves both asynchronous and synchronous modes.
// - Divisor n sets a free-running timer period of n plus one.
// - Async rate is clock over 64(n+1), or 16(n+1) with high-speed set; wide select makes these 16(n+1) and 4(n+1).
// - Sync mode ignores high-speed; rate is clock over 4(n+1).
// - In sync mode divisor timing applies only as master; slave takes the external clock.
// - Any divisor byte write clears the counter at once.
// - Runs on the system clock; software rewrites divisors if it changes.
// - Receive pin level is a majority vote of three samples.
// - Rate control bits 5 and 2 ignore writes and read zero.
// - Port enable turns the port and its pins on; clear disables it.
module srg_rate_gen (
  input wire logic clk,
  input wire logic resetn,
  input wire srg_pkg::srg_bus_t bus,
  input wire logic rx_in,
  input wire logic ext_clk_in,
  input wire logic rx_active,
  output logic [7:0] rdata,
  output logic bit_tick,
  output logic rx_level,
  output logic sck_out,
  output logic sck_oe,
  output logic pins_en,
  output logic irq
);
  import srg_pkg::*;

  srg_state_t s_reg;
  srg_state_t s_next;
  logic en;
  logic sync;
  logic hs;
  logic master;
  logic wide;
  logic own_clk;
  logic [6:0] pre_top;
  logic [15:0] top;
  logic pre_wrap;
  logic cnt_wrap;
  logic div_wr;
  logic cfg_wr;
  logic rx_fall;
  logic rx_rise;
  logic ext_edge;
  logic rx_idle;
  logic [7:0] rc_view;

  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // ************************************
  // Mode decode
  // ************************************
  always_comb begin
    en = s_reg.pc[SRG_PC_EN];
    sync = s_reg.pc[SRG_PC_SYNC];
    hs = s_reg.pc[SRG_PC_HS];
    master = s_reg.pc[SRG_PC_MASTER];
    wide = s_reg.rc[SRG_RC_WIDE];
    own_clk = master | ~sync;
    if (sync) begin
      pre_top = SRG_PRE_SYNC;
    end else if (wide) begin
      pre_top = hs ? SRG_PRE_4 : SRG_PRE_16;
    end else begin
      pre_top = hs ? SRG_PRE_16 : SRG_PRE_64;
    end
    top = wide ? s_reg.div : {8'h00, s_reg.div[7:0]};
    pre_wrap = s_reg.pre >= pre_top;
    cnt_wrap = pre_wrap & (s_reg.cnt >= top);
    div_wr = bus.wr & ((bus.addr == SRG_DIV_LOW) | (bus.addr == SRG_DIV_HIGH));
    cfg_wr = bus.wr & (bus.addr <= SRG_PORT_CONTROL);
    rx_fall = s_reg.rx_prev & ~s_reg.rx_lvl;
    rx_rise = ~s_reg.rx_prev & s_reg.rx_lvl;
    ext_edge = ext_clk_in & ~s_reg.ext_prev;
    rx_idle = ~rx_active & (s_reg.abd == SRG_ABD_IDLE);
    rc_view = s_reg.rc & SRG_RC_WMASK;
    rc_view[SRG_RC_IDLE] = rx_idle;
  end

  // ************************************
  // Next state
  // ************************************
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    s_next.rdata = 8'h00;
    // Register writes come first so hardware events win
    if (bus.wr) begin
      if (bus.addr == SRG_RATE_CONTROL) begin
        s_next.rc = bus.wdata & SRG_RC_WMASK;
      end else if (bus.addr == SRG_DIV_LOW) begin
        s_next.div[7:0] = bus.wdata;
      end else if (bus.addr == SRG_DIV_HIGH) begin
        s_next.div[15:8] = bus.wdata;
      end else if (bus.addr == SRG_PORT_CONTROL) begin
        s_next.pc = bus.wdata & SRG_PC_WMASK;
      end else if (bus.addr == SRG_IRQ_STATUS) begin
        s_next.ist = s_reg.ist & ~bus.wdata[2:0];
      end else if (bus.addr == SRG_IRQ_MASK) begin
        s_next.imask = bus.wdata[2:0];
      end
    end
    if (bus.rd) begin
      if (bus.addr == SRG_RATE_CONTROL) begin
        s_next.rdata = rc_view;
      end else if (bus.addr == SRG_DIV_LOW) begin
        s_next.rdata = s_reg.div[7:0];
      end else if (bus.addr == SRG_DIV_HIGH) begin
        s_next.rdata = s_reg.div[15:8];
      end else if (bus.addr == SRG_PORT_CONTROL) begin
        s_next.rdata = s_reg.pc;
      end else if (bus.addr == SRG_IRQ_STATUS) begin
        s_next.rdata = {5'h00, s_reg.ist};
      end else if (bus.addr == SRG_IRQ_MASK) begin
        s_next.rdata = {5'h00, s_reg.imask};
      end else if (bus.addr == SRG_LINE_STATUS) begin
        s_next.rdata = {5'h00, s_reg.abd != SRG_ABD_IDLE, s_reg.sck, s_reg.rx_lvl};
      end
    end

    // ************************************
    // Receive pin vote
    // ************************************
    s_next.rx_hist = {s_reg.rx_hist[1:0], rx_in};
    s_next.rx_lvl = maj3(s_next.rx_hist);
    s_next.rx_prev = s_reg.rx_lvl;
    s_next.ext_prev = ext_clk_in;

    // ************************************
    // Shared divisor timer, system clock only
    // ************************************
    if (!en || div_wr || cfg_wr) begin
      s_next.pre = 7'h00;
      s_next.cnt = 16'h0000;
      s_next.sck = s_reg.rc[SRG_RC_POL];
    end else begin
      s_next.pre = pre_wrap ? 7'h00 : s_reg.pre + 7'h01;
      if (pre_wrap) begin
        s_next.cnt = cnt_wrap ? 16'h0000 : s_reg.cnt + 16'h0001;
      end
      if (!sync) begin
        s_next.tick = cnt_wrap;
        s_next.sck = s_reg.rc[SRG_RC_POL];
      end else if (master) begin
        // Half period per rollover gives clock over 4(n+1)
        if (cnt_wrap) begin
          s_next.sck = ~s_reg.sck;
          s_next.tick = s_reg.sck != s_reg.rc[SRG_RC_POL];
        end
      end else begin
        s_next.tick = ext_edge;
        s_next.sck = s_reg.rc[SRG_RC_POL];
      end
    end

    // ************************************
    // Auto rate detect
    // ************************************
    case (s_reg.abd)
      SRG_ABD_IDLE: begin
        if (en && !sync && s_reg.rc[SRG_RC_ARD]) begin
          s_next.abd = SRG_ABD_WAIT;
        end
      end
      SRG_ABD_WAIT: begin
        if (!s_next.rc[SRG_RC_ARD] || !en || sync) begin
          s_next.abd = SRG_ABD_IDLE;
        end else if (rx_fall) begin
          s_next.abd = SRG_ABD_MEAS;
          s_next.meas = 16'h0000;
          s_next.abd_sub = 3'h0;
          s_next.rises = 3'h0;
        end
      end
      SRG_ABD_MEAS: begin
        if (!s_next.rc[SRG_RC_ARD] || !en || sync) begin
          s_next.abd = SRG_ABD_IDLE;
        end else if (rx_rise && s_reg.rises == SRG_ABD_RISES) begin
          s_next.div = s_reg.meas;
          s_next.rc[SRG_RC_ARD] = 1'b0;
          s_next.ist[SRG_IRQ_DONE] = 1'b1;
          s_next.abd = SRG_ABD_IDLE;
        end else begin
          if (rx_rise) begin
            s_next.rises = s_reg.rises + 3'h1;
          end
          if (pre_wrap) begin
            s_next.abd_sub = s_reg.abd_sub + 3'h1;
            if (s_reg.abd_sub == SRG_ABD_SUB) begin
              s_next.meas = s_reg.meas + 16'h0001;
              if (s_reg.meas == 16'hffff) begin
                s_next.rc[SRG_RC_OVF] = 1'b1;
                s_next.ist[SRG_IRQ_OVF] = 1'b1;
              end
            end
          end
        end
      end
      default: begin
        s_next.abd = SRG_ABD_IDLE;
      end
    endcase

    // ************************************
    // Wake on receive
    // ************************************
    if (!s_next.rc[SRG_RC_WAKE] || !en || sync) begin
      s_next.wake_arm = 1'b0;
    end else if (s_reg.wake_arm && rx_rise) begin
      s_next.rc[SRG_RC_WAKE] = 1'b0;
      s_next.wake_arm = 1'b0;
    end else if (rx_fall) begin
      s_next.ist[SRG_IRQ_WAKE] = 1'b1;
      s_next.wake_arm = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= SRG_STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************
  // Outputs
  // ************************************
  assign rdata = s_reg.rdata;
  assign bit_tick = s_reg.tick;
  assign rx_level = s_reg.rx_lvl;
  assign sck_out = s_reg.sck;
  assign sck_oe = en & sync & master;
  assign pins_en = en;
  assign irq = |(s_reg.ist & s_reg.imask);

  // ************************************
  // Assertions
  // ************************************
  a_div_write_clear: assert property (@(posedge clk) disable iff (!resetn)
    div_wr |=> (s_reg.cnt == 16'h0000) && (s_reg.pre == 7'h00))
    else $error("divisor write did not clear timer");

  a_narrow_high_ignored: assert property (@(posedge clk) disable iff (!resetn)
    !wide |-> s_reg.cnt[15:8] == 8'h00)
    else $error("8-bit counter used high byte");

  a_async_slow_tick: assert property (@(posedge clk) disable iff (!resetn)
    en && !sync && !wide && !hs && !bus.wr && s_reg.pre == 7'h3f && s_reg.cnt == top
    |=> s_reg.tick)
    else $error("async divide by 64 missed tick");

  a_async_fast_pre: assert property (@(posedge clk) disable iff (!resetn)
    en && !sync && !wide && hs && !bus.wr |=> s_reg.pre <= 7'h0f)
    else $error("high-speed prescale too long");

  a_sync_pre: assert property (@(posedge clk) disable iff (!resetn)
    en && sync && !bus.wr |=> s_reg.pre <= 7'h01)
    else $error("sync prescale ignores high-speed wrongly");

  a_slave_tick: assert property (@(posedge clk) disable iff (!resetn)
    en && sync && !master && ext_edge |=> s_reg.tick)
    else $error("slave tick not taken from external clock");

  a_rx_vote: assert property (@(posedge clk) disable iff (!resetn)
    !rx_in [*3] |=> ##1 !s_reg.rx_lvl)
    else $error("majority vote did not follow low level");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
    bus.rd && bus.addr == SRG_RATE_CONTROL |=> rdata[5] == 1'b0 && rdata[2] == 1'b0)
    else $error("reserved rate control bits read nonzero");

  a_disabled_quiet: assert property (@(posedge clk) disable iff (!resetn)
    !en |=> s_reg.cnt == 16'h0000 && !s_reg.tick)
    else $error("disabled port timer running");

  a_ovf_sticky: assert property (@(posedge clk) disable iff (!resetn)
    s_reg.rc[SRG_RC_OVF] && !(bus.wr && bus.addr == SRG_RATE_CONTROL)
    |=> s_reg.rc[SRG_RC_OVF])
    else $error("rollover flag lost");

  a_wake_irq: assert property (@(posedge clk) disable iff (!resetn)
    en && !sync && s_reg.rc[SRG_RC_WAKE] && rx_fall |=> s_reg.ist[SRG_IRQ_WAKE])
    else $error("wake edge did not set status");

  a_tick_single: assert property (@(posedge clk) disable iff (!resetn)
    s_reg.tick |=> !s_reg.tick)
    else $error("bit tick longer than one cycle");

  a_cfg_write_clear: assert property (@(posedge clk) disable iff (!resetn)
    cfg_wr |=> (s_reg.cnt == 16'h0000) && (s_reg.pre == 7'h00))
    else $error("configuration write did not clear timer");

  a_async_sck_idle: assert property (@(posedge clk) disable iff (!resetn)
    !sync |=> s_reg.sck == $past(s_reg.rc[SRG_RC_POL]))
    else $error("async clock output left idle level");

  a_sync_toggle: assert property (@(posedge clk) disable iff (!resetn)
    en && sync && master && cnt_wrap && !bus.wr |=> s_reg.sck != $past(s_reg.sck))
    else $error("sync master clock did not toggle");

  a_slave_sck_idle: assert property (@(posedge clk) disable iff (!resetn)
    en && sync && !master && !bus.wr |=> s_reg.sck == $past(s_reg.rc[SRG_RC_POL]))
    else $error("slave drove its own clock");

  a_rdata_idle: assert property (@(posedge clk) disable iff (!resetn)
    !bus.rd |=> rdata == 8'h00)
    else $error("read data outside read cycle");

  a_rc_unimpl_store: assert property (@(posedge clk) disable iff (!resetn)
    s_reg.rc[5] == 1'b0 && s_reg.rc[2] == 1'b0)
    else $error("unimplemented rate control bit stored");

  a_vote_high: assert property (@(posedge clk) disable iff (!resetn)
    rx_in [*3] |=> ##1 s_reg.rx_lvl)
    else $error("majority vote did not follow high level");

  a_abd_sync_off: assert property (@(posedge clk) disable iff (!resetn)
    sync |=> s_reg.abd == SRG_ABD_IDLE)
    else $error("auto rate detect active in sync mode");

  a_abd_load: assert property (@(posedge clk) disable iff (!resetn)
    s_reg.abd == SRG_ABD_MEAS && rx_rise && s_reg.rises == SRG_ABD_RISES && en && !sync
    && s_reg.rc[SRG_RC_ARD] && !cfg_wr |=> !s_reg.rc[SRG_RC_ARD] && s_reg.ist[SRG_IRQ_DONE])
    else $error("auto rate detect did not finish");

  a_ovf_idle: assert property (@(posedge clk) disable iff (!resetn)
    s_reg.abd == SRG_ABD_IDLE && !cfg_wr |=> s_reg.rc[SRG_RC_OVF] == $past(s_reg.rc[SRG_RC_OVF]))
    else $error("rollover flag changed outside measurement");

  a_done_sticky: assert property (@(posedge clk) disable iff (!resetn)
    s_reg.ist[SRG_IRQ_DONE] && !(bus.wr && bus.addr == SRG_IRQ_STATUS)
    |=> s_reg.ist[SRG_IRQ_DONE])
    else $error("auto rate done status lost");

  a_wake_clear: assert property (@(posedge clk) disable iff (!resetn)
    en && !sync && s_reg.rc[SRG_RC_WAKE] && s_reg.wake_arm && rx_rise
    |=> !s_reg.rc[SRG_RC_WAKE])
    else $error("wake enable not cleared on rising edge");

  a_disabled_no_abd: assert property (@(posedge clk) disable iff (!resetn)
    !en |=> s_reg.abd == SRG_ABD_IDLE)
    else $error("auto rate detect active while disabled");

  c_async_tick: cover property (@(posedge clk) disable iff (!resetn)
    en && !sync && s_reg.tick);
  c_sync_master: cover property (@(posedge clk) disable iff (!resetn)
    sck_oe && s_reg.tick);
  c_abd_done: cover property (@(posedge clk) disable iff (!resetn)
    s_reg.abd == SRG_ABD_MEAS ##1 s_reg.abd == SRG_ABD_IDLE);
  c_wake: cover property (@(posedge clk) disable iff (!resetn)
    s_reg.wake_arm ##1 !s_reg.rc[SRG_RC_WAKE]);
  c_slave_tick: cover property (@(posedge clk) disable iff (!resetn)
    en && sync && !master && s_reg.tick);
endmodule

/* verification/srg_partner.sv */
// Remote transceiver model: sync field sender and slave bit clock
`timescale 1ns/10ps
module srg_partner #(
  parameter int BIT_CLKS = 128,
  parameter int EXT_HALF = 10
) (
  input wire logic clk,
  input wire logic go,
  input wire logic glitch,
  input wire logic ext_run,
  output logic rx_line,
  output logic ext_clk,
  output logic busy
);
  logic [9:0] frame;
  int idx;
  int cnt;
  int ecnt;
  initial begin
    ext_clk = 1'b0;
    busy = 1'b0;
    frame = 10'h2aa;
    idx = 0;
    cnt = 0;
    ecnt = 0;
  end
  // Idle line is high; a glitch pulls it low for one cycle
  always_comb rx_line = (busy ? frame[idx] : 1'b1) & ~glitch;
  always @(posedge clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      idx <= 0;
      cnt <= 0;
    end else if (busy) begin
      if (cnt == BIT_CLKS - 1) begin
        cnt <= 0;
        if (idx == 9) busy <= 1'b0;
        else idx <= idx + 1;
      end else cnt <= cnt + 1;
    end
    // Slave clock stands still at low outside use
    if (ext_run) begin
      ecnt <= (ecnt == EXT_HALF - 1) ? 0 : ecnt + 1;
      if (ecnt == EXT_HALF - 1) ext_clk <= ~ext_clk;
    end else begin
      ecnt <= 0;
      ext_clk <= 1'b0;
    end
  end
endmodule

/* verification/tb_srg_rate_gen.sv */
// Testbench for the serial rate generator
`timescale 1ns/10ps
module tb_srg_rate_gen;
  import srg_pkg::*;
  logic clk;
  logic resetn;
  srg_bus_t bus;
  logic rx_in, ext_clk_in, rx_active, go, glitch, ext_run;
  logic [7:0] rdata;
  logic bit_tick, rx_level, sck_out, sck_oe, pins_en, irq;
  int num_errors = 0;
  int check_count = 0;
  logic [7:0] d;
  int t1, t2;
  logic [7:0] pcs [6] = '{8'h01, 8'h05, 8'h01, 8'h05, 8'h0f, 8'h0b};
  logic [7:0] rcs [6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08};
  logic [7:0] his [6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00};
  logic [7:0] los [6] = '{8'h02, 8'h02, 8'h00, 8'h00, 8'h02, 8'h05};
  int pers [6] = '{192, 48, 4112, 1028, 12, 24};
  srg_rate_gen uut (.clk(clk), .resetn(resetn), .bus(bus), .rx_in(rx_in),
    .ext_clk_in(ext_clk_in), .rx_active(rx_active), .rdata(rdata), .bit_tick(bit_tick),
    .rx_level(rx_level), .sck_out(sck_out), .sck_oe(sck_oe), .pins_en(pins_en), .irq(irq));
  srg_partner #(.BIT_CLKS(128), .EXT_HALF(10)) peer (.clk(clk), .go(go), .glitch(glitch),
    .ext_run(ext_run), .rx_line(rx_in), .ext_clk(ext_clk_in), .busy(rx_active));
  // ************************************
  // Bus and check tasks
  // ************************************
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 v = rdata;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wait_tick(input int lim, output int t);
    t = 0;
    do begin
      @(posedge clk);
      #1 t++;
    end while (bit_tick !== 1'b1 && t < lim);
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    wrap_up;
  end
  // ************************************
  // Tests
  // ************************************
  initial begin
    resetn = 1'b0;
    bus = '0;
    go = 1'b0;
    glitch = 1'b0;
    ext_run = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd(SRG_RATE_CONTROL, d);
    chk("rc reset", 8'h40, d);
    wr(SRG_RATE_CONTROL, 8'h24);
    rd(SRG_RATE_CONTROL, d);
    chk("rc unimpl", 8'h40, d);
    rd(3'h7, d);
    chk("unmapped", 8'h00, d);
    for (int i = 0; i < 6; i++) begin
      wr(SRG_RATE_CONTROL, rcs[i]);
      wr(SRG_PORT_CONTROL, pcs[i]);
      wr(SRG_DIV_HIGH, his[i]);
      wr(SRG_DIV_LOW, los[i]);
      wait_tick(9000, t1);
      wait_tick(9000, t2);
      chk("period", pers[i], t2);
      chk("first tick", 1, t1 <= pers[i] + 2);
      chk("sck oe", pcs[i][3], sck_oe);
    end
    wr(SRG_PORT_CONTROL, 8'h03);
    @(posedge clk);
    ext_run <= 1'b1;
    wait_tick(200, t1);
    wait_tick(200, t2);
    chk("slave period", 20, t2);
    chk("slave oe", 1'b0, sck_oe);
    @(posedge clk);
    ext_run <= 1'b0;
    wr(SRG_PORT_CONTROL, 8'h00);
    wait_tick(300, t1);
    chk("no tick off", 300, t1);
    chk("pins off", 1'b0, pins_en);
    wr(SRG_RATE_CONTROL, 8'h10);
    @(posedge clk);
    #1 chk("sck idle", 1'b1, sck_out);
    @(posedge clk);
    glitch <= 1'b1;
    @(posedge clk);
    glitch <= 1'b0;
    repeat (4) begin
      @(posedge clk);
      #1 chk("vote", 1'b1, rx_level);
    end
    wr(SRG_PORT_CONTROL, 8'h05);
    wr(SRG_RATE_CONTROL, 8'h02);
    wr(SRG_IRQ_MASK, 8'h00);
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (40) @(posedge clk);
    chk("rx low", 1'b0, rx_level);
    chk("masked", 1'b0, irq);
    rd(SRG_RATE_CONTROL, d);
    chk("busy rc", 8'h02, d);
    rd(SRG_IRQ_STATUS, d);
    chk("wake st", 8'h01, d);
    wr(SRG_IRQ_MASK, 8'h01);
    #1 chk("irq on", 1'b1, irq);
    repeat (1300) @(posedge clk);
    rd(SRG_RATE_CONTROL, d);
    chk("wue off", 8'h40, d);
    wr(SRG_IRQ_STATUS, 8'h01);
    #1 chk("irq clr", 1'b0, irq);
    wr(SRG_RATE_CONTROL, 8'h01);
    wr(SRG_IRQ_MASK, 8'h02);
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (1340) @(posedge clk);
    rd(SRG_RATE_CONTROL, d);
    chk("abd off", 8'h40, d);
    rd(SRG_IRQ_STATUS, d);
    chk("abd st", 8'h02, d);
    chk("abd irq", 1'b1, irq);
    rd(SRG_DIV_LOW, d);
    chk("abd div", 1'b1, d >= 8'h08 && d <= 8'h0a);
    wrap_up;
  end
endmodule
